// ### pcl_counter.v
// Purpose: one 32-bit pulse counter channel, linear or ring, with presets
// Assumes: pulse and phase Z inputs are asynchronous and slower than pclk/4
// Notes: registers over APB, zero wait states
// Notes: control bits are levels; software writes a command bit 1, then 0
// Notes: a saturated linear count ignores pulses in both directions until a preset
`include "pcl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pcl_counter #(
  parameter integer HOLD_US = `PCL_HOLD_US
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cnt_up_pulse,
  input wire cnt_dn_pulse,
  input wire phase_z,
  output reg [31:0] count_value_r,
  output reg ext_preset_request_flag,
  output reg ovun_error
);
  localparam integer HOLD_CYC_I = (`PCL_CLK_HZ / 1000000) * HOLD_US;
  localparam [31:0] HOLD_CYC = HOLD_CYC_I;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  // bit 0 up pulse, bit 1 down pulse, bit 2 phase z
  // only the second stage is read by logic; the third is edge history
  wire [2:0] pin_in = {phase_z, cnt_dn_pulse, cnt_up_pulse};
  wire [2:0] s2_w;
  wire [2:0] s3_w;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg m1_r;
      reg m2_r;
      reg m3_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          m1_r <= 1'b0;
          m2_r <= 1'b0;
          m3_r <= 1'b0;
        end else begin
          m1_r <= pin_in[gi];
          m2_r <= m1_r;
          m3_r <= m2_r;
        end
      end
      assign s2_w[gi] = m2_r;
      assign s3_w[gi] = m3_r;
    end
  endgenerate
  // history resets low, the idle level of every pin, so no false edge after reset
  wire up_ev = s2_w[0] & ~s3_w[0];
  wire dn_ev = s2_w[1] & ~s3_w[1];
  wire z_lvl = s2_w[2];
  wire z_rise = s2_w[2] & ~s3_w[2];
  wire z_fall = ~s2_w[2] & s3_w[2];

  // true when a linear step in the given direction would leave the signed range
  function at_limit;
    input [31:0] v;
    input up;
    begin
      if (up)
        at_limit = (v == `PCL_CNT_MAX);
      else
        at_limit = (v == `PCL_CNT_MIN);
    end
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg count_enable_cmd;
  reg program_preset_cmd;
  reg ext_preset_request_clear_cmd;
  reg cfg_ring_r;
  reg [1:0] cfg_trig_r;
  reg cfg_reqdet_r;
  reg [31:0] preset_val_r;
  reg [31:0] ring_lo_wr_r;
  reg [31:0] ring_hi_wr_r;
  reg [31:0] ring_lo_r;
  reg [31:0] ring_hi_r;
  reg [1:0] limit_flag_r;
  reg en_d_r;
  reg pre_d_r;
  reg [31:0] off_cnt_r;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  wire wr_go = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_enable_cmd <= 1'b0;
      program_preset_cmd <= 1'b0;
      ext_preset_request_clear_cmd <= 1'b0;
      cfg_ring_r <= 1'b0;
      cfg_trig_r <= `PCL_TRIG_RISE;
      cfg_reqdet_r <= 1'b0;
      preset_val_r <= `PCL_ZERO32;
      ring_lo_wr_r <= `PCL_ZERO32;
      ring_hi_wr_r <= `PCL_ZERO32;
    end else if (wr_go) begin
      case (paddr)
        `PCL_OFF_CTRL: begin
          count_enable_cmd <= pwdata[`PCL_CTRL_EN];
          program_preset_cmd <= pwdata[`PCL_CTRL_PRESET];
          ext_preset_request_clear_cmd <= pwdata[`PCL_CTRL_REQCLR];
        end
        `PCL_OFF_CFG: begin
          cfg_ring_r <= pwdata[`PCL_CFG_RING];
          cfg_trig_r <= pwdata[`PCL_CFG_TRIG_MSB:`PCL_CFG_TRIG_LSB];
          cfg_reqdet_r <= pwdata[`PCL_CFG_REQDET];
        end
        `PCL_OFF_PRESET: preset_val_r <= pwdata;
        `PCL_OFF_RING_LO: ring_lo_wr_r <= pwdata;
        `PCL_OFF_RING_HI: ring_hi_wr_r <= pwdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // enable edge, limit latch, preset triggers
  // --------------------------------------------------------------------------
  wire en_rise = count_enable_cmd & ~en_d_r;
  wire pre_rise = program_preset_cmd & ~pre_d_r;
  reg z_hit;
  always @* begin
    case (cfg_trig_r)
      `PCL_TRIG_RISE: z_hit = z_rise;
      `PCL_TRIG_FALL: z_hit = z_fall;
      `PCL_TRIG_BOTH: z_hit = z_rise | z_fall;
      `PCL_TRIG_LEVEL: z_hit = z_lvl;
      default: z_hit = 1'b0;
    endcase
  end
  wire z_is_lvl = (cfg_trig_r == `PCL_TRIG_LEVEL);
  wire preset_req = z_hit | pre_rise;
  wire preset_go = preset_req & ~ext_preset_request_flag;
  wire [31:0] hi_m1 = ring_hi_r - 32'h00000001;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_r <= 1'b0;
      pre_d_r <= 1'b0;
      ring_lo_r <= `PCL_ZERO32;
      ring_hi_r <= `PCL_ZERO32;
      off_cnt_r <= `PCL_ZERO32;
    end else begin
      en_d_r <= count_enable_cmd;
      pre_d_r <= program_preset_cmd;
      if (count_enable_cmd)
        off_cnt_r <= `PCL_ZERO32;
      else if (off_cnt_r != HOLD_CYC)
        off_cnt_r <= off_cnt_r + 32'h00000001;
      // limits load on enable rising edge after a full off time, or on any enable rise in linear mode or when ring_hi_r equals ring_lo_r
      if (en_rise && (off_cnt_r == HOLD_CYC || !cfg_ring_r || ring_hi_r == ring_lo_r)) begin
        ring_lo_r <= ring_lo_wr_r;
        ring_hi_r <= ring_hi_wr_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // counter core
  // --------------------------------------------------------------------------
  wire step_up = count_enable_cmd & up_ev & ~dn_ev;
  wire step_dn = count_enable_cmd & dn_ev & ~up_ev;
  wire step_any = step_up | step_dn;
  // linear step that would pass a limit; shared by count, flags and error
  wire lin_hit = ~cfg_ring_r & step_any & at_limit(count_value_r, step_up);
  // any set limit flag freezes the linear count until a preset
  wire lin_hold = (limit_flag_r != 2'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= `PCL_ZERO32;
      limit_flag_r <= 2'h0;
      ext_preset_request_flag <= 1'b0;
      ovun_error <= 1'b0;
    end else begin
      if (preset_go) begin
        count_value_r <= preset_val_r;
        limit_flag_r <= 2'h0;
      end else if (cfg_ring_r) begin
        // ring never saturates or errors
        if (step_up) begin
          if (count_value_r == hi_m1)
            count_value_r <= ring_lo_r;
          else
            count_value_r <= count_value_r + 32'h00000001;
        end else if (step_dn) begin
          if (count_value_r == ring_lo_r)
            count_value_r <= hi_m1;
          else
            count_value_r <= count_value_r - 32'h00000001;
        end
      end else if (lin_hold) begin
        // saturated: further pulses are ignored until a preset
        count_value_r <= count_value_r;
      end else if (lin_hit) begin
        if (step_up)
          limit_flag_r[1] <= 1'b1;
        else
          limit_flag_r[0] <= 1'b1;
      end else if (step_up) begin
        count_value_r <= count_value_r + 32'h00000001;
      end else if (step_dn) begin
        count_value_r <= count_value_r - 32'h00000001;
      end
      // a preset in the same cycle wins so flags, error and count stay consistent
      if (lin_hit && !preset_go)
        ovun_error <= 1'b1;
      else if (preset_go)
        ovun_error <= 1'b0;
      // set wins over the clear command
      if (z_hit && preset_go && cfg_reqdet_r && !z_is_lvl)
        ext_preset_request_flag <= 1'b1;
      else if (ext_preset_request_clear_cmd)
        ext_preset_request_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  // ring limit offsets read back the written values, not the armed ones
  // unmapped offsets read zero and never raise an error
  always @* begin
    case (paddr)
      `PCL_OFF_COUNT: prdata = count_value_r;
      `PCL_OFF_FLAGS: prdata = {28'h0000000, ext_preset_request_flag,
                                limit_flag_r[1], limit_flag_r[0], 1'b0};
      `PCL_OFF_CTRL: prdata = {29'h00000000, ext_preset_request_clear_cmd,
                               program_preset_cmd, count_enable_cmd};
      `PCL_OFF_CFG: prdata = {28'h0000000, cfg_reqdet_r, cfg_trig_r, cfg_ring_r};
      `PCL_OFF_PRESET: prdata = preset_val_r;
      `PCL_OFF_RING_LO: prdata = ring_lo_wr_r;
      `PCL_OFF_RING_HI: prdata = ring_hi_wr_r;
      `PCL_OFF_ERR: prdata = ovun_error ? {16'h0000, `PCL_ERR_OVUN} : `PCL_ZERO32;
      default: prdata = `PCL_ZERO32;
    endcase
  end
endmodule
`default_nettype wire

// ### pcl_counter_properties.sv
// Purpose: port checks for pcl_counter
// Assumes: zero wait state apb
// Notes: bound into every pcl_counter
`include "pcl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pcl_checks (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [31:0] count_value_r,
  input wire logic ext_preset_request_flag,
  input wire logic ovun_error
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = psel && penable && !pwrite;
  wire logic f = ext_preset_request_flag;
  wire logic [31:0] c = count_value_r;
  property p_sat; ovun_error |-> c == `PCL_CNT_MIN || c == `PCL_CNT_MAX; endproperty
  a_sat: assert property (p_sat) else $error("error without saturated count");
  property p_rise; $rose(ovun_error) |-> $stable(c); endproperty
  a_rise: assert property (p_rise) else $error("count moved at limit");
  property p_stay; ovun_error && $past(ovun_error) |-> $stable(c); endproperty
  a_stay: assert property (p_stay) else $error("count left limit");
  property p_err; rd && paddr == `PCL_OFF_ERR && ovun_error |-> prdata[15:0] == `PCL_ERR_OVUN;
  endproperty
  a_err: assert property (p_err) else $error("bad error code");
  property p_flg; rd && paddr == `PCL_OFF_FLAGS |-> (prdata[2:1] != 2'h0) == ovun_error;
  endproperty
  a_flg: assert property (p_flg) else $error("limit flags disagree");
  property p_req; rd && paddr == `PCL_OFF_FLAGS |-> prdata[3] == f; endproperty
  a_req: assert property (p_req) else $error("request flag read wrong");
  property p_cnt; rd && paddr == `PCL_OFF_COUNT |-> prdata == c; endproperty
  a_cnt: assert property (p_cnt) else $error("count read wrong");
  property p_blk; f && $past(f) |-> (c - $past(c)) inside {32'h0, 32'h1, 32'hffffffff};
  endproperty
  a_blk: assert property (p_blk) else $error("preset while blocked");
  c_ov: cover property ($rose(ovun_error));
  c_req: cover property ($rose(f));
  c_clr: cover property ($fell(f));
endmodule
bind pcl_counter pcl_checks u_chk (.*);
`default_nettype wire

// ### pcl_encoder.sv
// Purpose: encoder pulse source for the counter bench
// Assumes: bursts of n steps in one direction
// Notes: 8 cycle pulse period, pins low between bursts
`timescale 1ns/1ps
`default_nettype none
module pcl_encoder (
  input wire logic pclk,
  input wire logic go,
  input wire logic dir_up,
  input wire logic [7:0] n,
  output logic busy,
  output logic cnt_up_pulse,
  output logic cnt_dn_pulse
);
  // ------
  // bursts
  // ------
  logic [7:0] left_r = 8'h00;
  logic [2:0] ph_r = 3'h0;
  assign busy = left_r != 8'h00;
  assign cnt_up_pulse = busy && ph_r[2] && dir_up;
  assign cnt_dn_pulse = busy && ph_r[2] && !dir_up;
  always @(posedge pclk) begin
    if (go) begin
      left_r <= n;
      ph_r <= 3'h0;
    end else if (busy) begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == 3'h7) left_r <= left_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### pcl_map.vh
// Purpose: constants for the pulse counter channel with limits and preset
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
`ifndef PCL_MAP_VH
`define PCL_MAP_VH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PCL_OFF_COUNT 12'h000
`define PCL_OFF_FLAGS 12'h004
`define PCL_OFF_CTRL 12'h008
`define PCL_OFF_CFG 12'h00c
`define PCL_OFF_PRESET 12'h010
`define PCL_OFF_RING_LO 12'h014
`define PCL_OFF_RING_HI 12'h018
`define PCL_OFF_ERR 12'h01c
// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define PCL_FLG_UNDER 1
`define PCL_FLG_OVER 2
`define PCL_CTRL_EN 0
`define PCL_CTRL_PRESET 1
`define PCL_CTRL_REQCLR 2
`define PCL_CFG_RING 0
`define PCL_CFG_TRIG_LSB 1
`define PCL_CFG_TRIG_MSB 2
`define PCL_CFG_REQDET 3
`define PCL_TRIG_RISE 2'h0
`define PCL_TRIG_FALL 2'h1
`define PCL_TRIG_BOTH 2'h2
`define PCL_TRIG_LEVEL 2'h3
`define PCL_ERR_OVUN 16'h0c1c
`define PCL_CNT_MIN 32'h80000000
`define PCL_CNT_MAX 32'h7fffffff
`define PCL_ZERO32 32'h00000000
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PCL_CLK_HZ 50000000
`define PCL_HOLD_US 2000
`endif

// ### pulse_counter_limits_preset_bench.sv
// Purpose: self-checking bench for pcl_counter
// Assumes: HOLD_US of 1, so 50 cycles off re-arms ring limits
// Notes: xorshift stimulus with fixed seed
`include "pcl_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module pulse_counter_limits_preset_bench;
  logic pclk, presetn, psel, penable, pwrite, phase_z, go, dir_up, busy, pready, pslverr;
  logic cnt_up_pulse, cnt_dn_pulse, ext_preset_request_flag, ovun_error, en, ring;
  logic [11:0] paddr;
  logic [7:0] n;
  logic [31:0] pwdata, prdata, count_value_r, rd, cnt_e, lo, hi, k, r;
  logic [31:0] seed = 32'h5b4e1953;
  logic sat = 1'b0;
  int failures = 0;
  int comparisons = 0;
  pcl_counter #(.HOLD_US(1)) u_dut (.*);
  pcl_encoder u_enc (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ---------------
  // tasks and model
  // ---------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] f_nx(logic [31:0] c, logic up);
    if (ring) return up ? (c == hi - 1 ? lo : c + 1) : (c == lo ? hi - 1 : c - 1);
    if (sat) return c;
    if ((up && c == `PCL_CNT_MAX) || (!up && c == `PCL_CNT_MIN)) begin
      sat = 1'b1;
      return c;
    end
    return up ? c + 1 : c - 1;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    wr(a, 32'h0, 1'b0);
    `CHK(rd, e)
  endtask
  task automatic chkc;
    `CHK(count_value_r, cnt_e)
    rdc(`PCL_OFF_COUNT, cnt_e);
  endtask
  task automatic pset(input logic [31:0] v);
    wr(`PCL_OFF_PRESET, v);
    wr(`PCL_OFF_CTRL, {29'h0, 2'h1, en});
    wr(`PCL_OFF_CTRL, {31'h0, en});
    cnt_e = v;
    sat = 1'b0;
  endtask
  task automatic pulses(input logic up, input logic [7:0] cnt);
    go <= 1'b1;
    dir_up <= up;
    n <= cnt;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
    repeat (4) @(posedge pclk);
    if (en) repeat (cnt) cnt_e = f_nx(cnt_e, up);
  endtask
  task automatic finish_test;
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, phase_z, go, dir_up, en, ring} = 9'h0;
    {paddr, n, pwdata} = 52'h0;
    cnt_e = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chkc;
    rdc(12'h020, 32'h0);
    pset(rnd());
    chkc;
    pulses(1'b1, 8'h03);
    chkc;
    en = 1'b1;
    wr(`PCL_OFF_CTRL, 32'h1);
    repeat (6) begin
      r = rnd();
      pulses(r[0], {4'h0, r[4:1]});
      chkc;
    end
    pset(`PCL_CNT_MAX - 32'h1);
    pulses(1'b1, 8'h03);
    chkc;
    rdc(`PCL_OFF_FLAGS, 32'h4);
    rdc(`PCL_OFF_ERR, {16'h0, `PCL_ERR_OVUN});
    `CHK(ovun_error, 1'b1)
    pulses(1'b0, 8'h02);
    chkc;
    pset(32'h0);
    rdc(`PCL_OFF_FLAGS, 32'h0);
    pset(`PCL_CNT_MIN + 32'h1);
    pulses(1'b0, 8'h03);
    chkc;
    rdc(`PCL_OFF_FLAGS, 32'h2);
    en = 1'b0;
    wr(`PCL_OFF_CTRL, 32'h0);
    r = rnd();
    lo = 32'hffffff00 | {24'h0, r[7:0]};
    hi = {24'h0, r[15:8]} + 32'h10;
    wr(`PCL_OFF_RING_LO, lo);
    wr(`PCL_OFF_RING_HI, hi);
    wr(`PCL_OFF_CFG, 32'h1);
    ring = 1'b1;
    pset(hi - 32'h3);
    repeat (60) @(posedge pclk);
    en = 1'b1;
    wr(`PCL_OFF_CTRL, 32'h1);
    pulses(1'b1, 8'h04);
    chkc;
    pulses(1'b0, 8'h03);
    chkc;
    rdc(`PCL_OFF_FLAGS, 32'h0);
    {en, ring} = 2'h0;
    wr(`PCL_OFF_CTRL, 32'h0);
    for (int t = 0; t < 4; t++) begin
      k = rnd();
      wr(`PCL_OFF_CFG, {28'h0, 1'b1, t[1:0], 1'b0});
      wr(`PCL_OFF_PRESET, k);
      repeat (60) @(posedge pclk);
      phase_z <= 1'b1;
      repeat (8) @(posedge pclk);
      phase_z <= 1'b0;
      repeat (8) @(posedge pclk);
      cnt_e = k;
      chkc;
      rdc(`PCL_OFF_FLAGS, {28'h0, t != 3, 3'h0});
      `CHK(ext_preset_request_flag, t != 3)
      pset(~k);
      cnt_e = (t == 3) ? ~k : k;
      chkc;
      wr(`PCL_OFF_CTRL, 32'h4);
      wr(`PCL_OFF_CTRL, 32'h0);
      rdc(`PCL_OFF_FLAGS, 32'h0);
    end
    finish_test;
  end
endmodule
`default_nettype wire
